//--- sim/acq_memory_trigger_ctrl_tb.sv
// Self-checking bench for the acquisition memory and trigger block
`timescale 1ns/10ps
module acq_memory_trigger_ctrl_tb
  import acq_pkg::*;
();
  // ====================================================================
  // Signals
  logic                       core_clk = 1'b0;
  logic                       reset    = 1'b1;
  logic [NUM_CH*SAMPLE_W-1:0] adc_data;
  logic [NUM_CH*SAMPLE_W-1:0] thresholds;
  logic                       arm, start_cmd, stop_cmd, gate_pin, gate_mode;
  logic                       multi_event, single_shot, auto_start, dual_bank, bank_sel;
  logic                       trig_above, trig_on_started, trig_start_en, trig_stop_en;
  logic                       rd_req, rd_dir, rd_ack, rd_ready, rd_valid;
  logic                       trig_out, running, armed_out, active_bank;
  logic [3:0]                 size_shift;
  logic [OFF_W-1:0]           post_len, wr_ptr;
  logic [1:0]                 clr_full, rd_group, bank_full, src_mode;
  logic [MEM_AW-1:0]          rd_addr;
  logic [WORD_W-1:0]          rd_data;
  logic [PAGE_W-1:0]          page_num;
  logic [2:0]                 src_ch;
  int                         fail_count = 0;
  int                         num_checks = 0;

  // ====================================================================
  // Instances
  adc_source adc_source_i (.mode(src_mode), .sel_ch(src_ch), .adc_data);

  acq_memory_trigger_ctrl acq_memory_trigger_ctrl_i (
    .core_clk, .reset, .adc_data, .arm, .start_cmd, .stop_cmd, .gate_pin,
    .gate_mode, .multi_event, .single_shot, .auto_start, .size_shift, .post_len,
    .dual_bank, .bank_sel, .clr_full, .thresholds, .trig_above, .trig_on_started,
    .trig_start_en, .trig_stop_en, .rd_req, .rd_dir, .rd_group, .rd_addr,
    .rd_ready, .rd_valid, .rd_ack, .rd_data, .trig_out, .running, .armed_out,
    .bank_full, .active_bank, .page_num, .wr_ptr);

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ====================================================================
  // Helpers
  function automatic logic [SAMPLE_W-1:0] chv(input int c);
    return 12'h400 + 12'(c * 'h11);
  endfunction : chv

  function automatic logic [23:0] pick(input int w);
    case (w)
      0: return 24'(running);
      1: return 24'(active_bank);
      2: return 24'(rd_valid);
      3: return 24'(trig_out);
      4: return 24'(wr_ptr);
      5: return 24'(page_num);
      7: return 24'(rd_ready);
      default: return 24'(bank_full);
    endcase
  endfunction : pick

  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  // Bounded wait at falling edges; running out ends the run
  task automatic wait_for(input int w, input logic [23:0] val, input int n);
    int i;
    for (i = 0; i < n && pick(w) !== val; i++)
      @(negedge core_clk);
    num_checks++;
    if (pick(w) !== val)
    begin
      fail_count++;
      $display("[FAIL] %0t wait on signal %0d timed out", $time, w);
      complete_run();
    end
  endtask : wait_for

  task automatic hold(input int w, input logic [23:0] val, input int n);
    repeat (n)
    begin
      @(negedge core_clk);
      check(pick(w), val, "level not held");
    end
  endtask : hold

  task automatic go_idle();
    arm = 1'b0;
    src_mode = 2'h0;
    clr_full = 2'h3;
    @(negedge core_clk);
    clr_full = 2'h0;
    @(negedge core_clk);
  endtask : go_idle

  task automatic pulse_start();
    start_cmd = 1'b1;
    @(negedge core_clk);
    start_cmd = 1'b0;
  endtask : pulse_start

  task automatic arm_start();
    arm = 1'b1;
    @(negedge core_clk);
    check(armed_out, 1'b1, "not armed");
    pulse_start();
    wait_for(0, 24'h1, 4);
  endtask : arm_start

  // Request held until taken; host stalls before accepting the word
  task automatic read_word(input logic dir, input logic [1:0] grp,
                           input logic [MEM_AW-1:0] addr, input logic [23:0] exp);
    rd_dir = dir;
    rd_group = grp;
    rd_addr = addr;
    rd_req = 1'b1;
    wait_for(7, 24'h1, 20);
    @(negedge core_clk);
    rd_req = 1'b0;
    wait_for(2, 24'h1, 4);
    repeat (3) @(negedge core_clk);
    check(rd_valid, 1'b1, "word dropped during stall");
    check(rd_data, exp, "read word");
    rd_ack = 1'b1;
    @(negedge core_clk);
    rd_ack = 1'b0;
    check(rd_valid, 1'b0, "word not released");
  endtask : read_word

  // ====================================================================
  // Scenarios
  task automatic t_reset();
    @(negedge core_clk);
    check({running, armed_out, trig_out, bank_full, active_bank, page_num}, '0,
          "status after reset");
    check(wr_ptr, '0, "pointer after reset");
    @(negedge core_clk);
    check(rd_ready, 1'b1, "readout not ready");
  endtask : t_reset

  task automatic t_circ();
    size_shift = 4'ha;
    post_len = 17'h00005;
    arm_start();
    wait_for(4, 24'h7f, 200);
    @(negedge core_clk);
    check(wr_ptr, '0, "no wrap at segment end");
    check(running, 1'b1, "circular run ended");
    stop_cmd = 1'b1;
    @(negedge core_clk);
    stop_cmd = 1'b0;
    hold(0, 24'h1, 4);
    wait_for(0, 24'h0, 6);
    go_idle();
  endtask : t_circ

  task automatic t_multi();
    multi_event = 1'b1;
    auto_start = 1'b1;
    bank_sel = 1'b1;
    size_shift = 4'hb;
    arm_start();
    check(active_bank, 1'b1, "bank choice");
    wait_for(5, 24'h2, 400);
    check(running, 1'b1, "no restart on next page");
    go_idle();
    read_word(1'b1, 2'h0, {7'h0, 1'b1, 10'h000}, 24'h7f);
    read_word(1'b1, 2'h0, {7'h0, 1'b1, 10'h001}, 24'h7f);
    {multi_event, auto_start, bank_sel} = '0;
  endtask : t_multi

  task automatic t_dual();
    single_shot = 1'b1;
    dual_bank = 1'b1;
    size_shift = 4'ha;
    arm_start();
    wait_for(1, 24'h1, 200);
    check(bank_full, 2'h1, "first bank not full");
    read_word(1'b1, 2'h0, {7'h0, 1'b0, 10'h000}, 24'h7f);
    read_word(1'b0, 2'h2, {1'b0, 17'h00005}, {chv(5), chv(4)});
    pulse_start();
    wait_for(6, 24'h3, 300);
    wait_for(0, 24'h0, 4);
    clr_full = 2'h1;
    @(negedge core_clk);
    clr_full = 2'h0;
    check(bank_full, 2'h2, "clear of one bank");
    {single_shot, dual_bank} = '0;
    go_idle();
  endtask : t_dual

  task automatic t_trig();
    trig_start_en = 1'b1;
    src_ch = 3'h5;
    src_mode = 2'h1;
    hold(3, 24'h0, 6);
    arm = 1'b1;
    wait_for(3, 24'h1, 8);
    wait_for(0, 24'h1, 8);
    go_idle();
    thresholds[5*SAMPLE_W +: SAMPLE_W] = 12'h700;
    src_mode = 2'h1;
    arm = 1'b1;
    hold(0, 24'h0, 8);
    go_idle();
    thresholds = {NUM_CH{12'h200}};
    trig_above = 1'b0;
    src_mode = 2'h2;
    arm = 1'b1;
    wait_for(0, 24'h1, 8);
    go_idle();
    thresholds = {NUM_CH{12'h500}};
    trig_above = 1'b1;
    trig_start_en = 1'b0;
  endtask : t_trig

  task automatic t_trig_stop();
    trig_on_started = 1'b1;
    trig_stop_en = 1'b1;
    post_len = 17'h00002;
    src_mode = 2'h1;
    arm = 1'b1;
    hold(3, 24'h0, 6);
    pulse_start();
    wait_for(3, 24'h1, 8);
    wait_for(0, 24'h0, 16);
    go_idle();
    {trig_on_started, trig_stop_en} = '0;
  endtask : t_trig_stop

  task automatic t_gate();
    gate_mode = 1'b1;
    arm = 1'b1;
    hold(0, 24'h0, 4);
    gate_pin = 1'b1;
    wait_for(0, 24'h1, 8);
    hold(0, 24'h1, 6);
    gate_pin = 1'b0;
    wait_for(0, 24'h0, 12);
    go_idle();
    gate_mode = 1'b0;
  endtask : t_gate

  // ====================================================================
  // Main sequence
  initial
  begin
    {arm, start_cmd, stop_cmd, gate_pin, gate_mode, multi_event} = '0;
    {single_shot, auto_start, dual_bank, bank_sel, rd_req, rd_dir, rd_ack} = '0;
    {trig_on_started, trig_start_en, trig_stop_en} = '0;
    {size_shift, post_len, clr_full, rd_group, rd_addr, src_mode, src_ch} = '0;
    trig_above = 1'b1;
    thresholds = {NUM_CH{12'h500}};
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    t_reset();
    t_circ();
    t_multi();
    t_dual();
    t_trig();
    t_trig_stop();
    t_gate();
    complete_run();
  end
endmodule : acq_memory_trigger_ctrl_tb

//--- sim/adc_source.sv
// Converter model: steady per-channel levels with one excursion channel
`timescale 1ns/10ps
module adc_source
  import acq_pkg::*;
(
  // Bench control: 0 steady, 1 high excursion, 2 low excursion
  input  wire logic [1:0]                 mode,
  input  wire logic [2:0]                 sel_ch,
  // Samples, one per channel each clock
  output logic      [NUM_CH*SAMPLE_W-1:0] adc_data
);
  // ====================================================================
  // Levels
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      adc_data[c*SAMPLE_W +: SAMPLE_W] = 12'h400 + 12'(c * 'h11);
      if (c == int'(sel_ch) && mode == 2'h1)
        adc_data[c*SAMPLE_W +: SAMPLE_W] = 12'h600;
      else if (c == int'(sel_ch) && mode == 2'h2)
        adc_data[c*SAMPLE_W +: SAMPLE_W] = 12'h100;
    end
  end
endmodule : adc_source

//--- verilog/acq_memory_trigger_ctrl.sv
// Acquisition memory, paging, bank switching and threshold trigger
`timescale 1ns/10ps
module acq_memory_trigger_ctrl
  import acq_pkg::*;
(
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  // Converter samples, channel 0 in low bits
  input  wire logic [NUM_CH*SAMPLE_W-1:0]  adc_data,
  // Acquisition control
  input  wire logic                        arm,
  input  wire logic                        start_cmd,
  input  wire logic                        stop_cmd,
  input  wire logic                        gate_pin,
  input  wire logic                        gate_mode,
  input  wire logic                        multi_event,
  input  wire logic                        single_shot,
  input  wire logic                        auto_start,
  input  wire logic [3:0]                  size_shift,
  input  wire logic [OFF_W-1:0]            post_len,
  input  wire logic                        dual_bank,
  input  wire logic                        bank_sel,
  input  wire logic [1:0]                  clr_full,
  // Trigger setup
  input  wire logic [NUM_CH*SAMPLE_W-1:0]  thresholds,
  input  wire logic                        trig_above,
  input  wire logic                        trig_on_started,
  input  wire logic                        trig_start_en,
  input  wire logic                        trig_stop_en,
  // Readout
  input  wire logic                        rd_req,
  input  wire logic                        rd_dir,
  input  wire logic [1:0]                  rd_group,
  input  wire logic [MEM_AW-1:0]           rd_addr,
  output logic                             rd_ready,
  output logic                             rd_valid,
  input  wire logic                        rd_ack,
  output logic      [WORD_W-1:0]           rd_data,
  // Status
  output logic                             trig_out,
  output logic                             running,
  output logic                             armed_out,
  output logic      [1:0]                  bank_full,
  output logic                             active_bank,
  output logic      [PAGE_W-1:0]           page_num,
  output logic      [OFF_W-1:0]            wr_ptr
);

  // ====================================================================
  // Registers
  acq_state_t        state_r, state_nxt;
  logic [OFF_W-1:0]  wr_off_r, wr_off_nxt;
  logic [PAGE_W-1:0] page_r, page_nxt;
  logic [OFF_W-1:0]  post_cnt_r, post_cnt_nxt;
  logic              bank_r, bank_nxt;
  logic [1:0]        full_r;
  logic              trig_r;
  logic              gate_s1_r, gate_s2_r, gate_d_r;
  logic              rd_ready_r, pend_r;
  logic [1:0]        grp_r;
  logic              dir_sel_r;

  // ====================================================================
  // Gate pin synchroniser and edges
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      gate_s1_r <= 1'b0;
      gate_s2_r <= 1'b0;
      gate_d_r  <= 1'b0;
    end
    else
    begin
      gate_s1_r <= gate_pin;
      gate_s2_r <= gate_s1_r;
      gate_d_r  <= gate_s2_r;
    end
  end

  wire gate_rise = gate_s2_r & ~gate_d_r;
  wire gate_fall = ~gate_s2_r & gate_d_r;

  // ====================================================================
  // Threshold compare per channel
  logic [NUM_CH-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_cmp
      wire [SAMPLE_W-1:0] smp = adc_data[gi*SAMPLE_W +: SAMPLE_W];
      wire [SAMPLE_W-1:0] thr = thresholds[gi*SAMPLE_W +: SAMPLE_W];
      assign hit[gi] = trig_above ? (smp > thr) : (smp < thr);
    end
  endgenerate

  wire any_hit  = |hit;
  wire is_idle  = (state_r == ST_IDLE);
  wire started  = (state_r == ST_RUN) || (state_r == ST_POST);
  wire trig_win = trig_on_started ? started : !is_idle;
  wire trig_now = any_hit & trig_win;

  // ====================================================================
  // Start and stop sources
  wire start_ev = start_cmd | (gate_mode & gate_rise)
                | (trig_start_en & !trig_on_started & trig_now);
  wire stop_ev  = stop_cmd | (gate_mode & gate_fall)
                | (trig_stop_en & trig_on_started & trig_now);

  // ====================================================================
  // Segment geometry, same for both banks
  wire [OFF_W-1:0]  mask      = seg_mask(size_shift);
  wire [3:0]        sh_c      = clip_shift(size_shift);
  wire [PAGE_W-1:0] pg_all    = PAGE_W'((11'h001 << sh_c) - 11'h001);
  wire [PAGE_W-1:0] page_last = multi_event ? pg_all : PAGE_RST;
  wire              off_end   = (wr_off_r == mask);
  wire              writing   = started;
  wire              post_done = (state_r == ST_POST) && (post_cnt_r == OFF_RST);
  wire              ev_end    = post_done || (writing && (single_shot || multi_event) && off_end);
  wire              last_pg   = (page_r == page_last);
  wire              other_ok  = dual_bank && !full_r[~bank_r];
  wire [OFF_W-1:0]  off_inc   = (wr_off_r + 17'h00001) & mask;
  wire              bank_ok   = !full_r[bank_r];

  // ====================================================================
  // Sequencer
  always_comb
  begin
    state_nxt    = state_r;
    wr_off_nxt   = wr_off_r;
    page_nxt     = page_r;
    post_cnt_nxt = post_cnt_r;
    bank_nxt     = bank_r;
    case (state_r)
      ST_IDLE:
      begin
        if (arm)
        begin
          state_nxt  = ST_ARMED;
          bank_nxt   = bank_sel;
          page_nxt   = PAGE_RST;
          wr_off_nxt = OFF_RST;
        end
      end
      ST_ARMED:
      begin
        if (start_ev && bank_ok)
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        wr_off_nxt = off_inc;
        if (stop_ev)
        begin
          state_nxt    = ST_POST;
          post_cnt_nxt = post_len;
        end
      end
      ST_POST:
      begin
        wr_off_nxt   = off_inc;
        post_cnt_nxt = post_cnt_r - 17'h00001;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
    if (ev_end)
    begin
      wr_off_nxt = OFF_RST;
      if (!last_pg)
      begin
        page_nxt  = page_r + 10'h001;
        state_nxt = auto_start ? ST_RUN : ST_ARMED;
      end
      else if (other_ok)
      begin
        bank_nxt  = ~bank_r;
        page_nxt  = PAGE_RST;
        state_nxt = auto_start ? ST_RUN : ST_ARMED;
      end
      else
        state_nxt = ST_IDLE;
    end
    if (!arm)
      state_nxt = ST_IDLE;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_r    <= ST_IDLE;
      wr_off_r   <= OFF_RST;
      page_r     <= PAGE_RST;
      post_cnt_r <= OFF_RST;
      bank_r     <= 1'b0;
      trig_r     <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      wr_off_r   <= wr_off_nxt;
      page_r     <= page_nxt;
      post_cnt_r <= post_cnt_nxt;
      bank_r     <= bank_nxt;
      trig_r     <= trig_now;
    end
  end

  // Bank full flags; a set in the clearing cycle wins
  wire [1:0] full_set = (ev_end && last_pg) ? (2'h1 << bank_r) : FULL_RST;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      full_r <= FULL_RST;
    else
      full_r <= (full_r & ~clr_full) | full_set;
  end

  // ====================================================================
  // Sample memories, one per channel pair
  wire [MEM_AW-1:0] wr_addr = {bank_r, page_base(page_r, size_shift) | wr_off_r};
  wire              rd_take = rd_req & rd_ready_r;
  logic [WORD_W-1:0] grp_rd [NUM_GRP];

  generate
    for (gi = 0; gi < NUM_GRP; gi++)
    begin : g_grp
      sample_store #(.AW(MEM_AW), .DW(WORD_W)) u_mem (
        .core_clk (core_clk),
        .we       (writing),
        .waddr    (wr_addr),
        .wdata    (adc_data[gi*WORD_W +: WORD_W]),
        .re       (rd_take & !rd_dir),
        .raddr    (rd_addr),
        .rdata    (grp_rd[gi])
      );
    end
  endgenerate

  // ====================================================================
  // Stop pointer directory, indexed by bank and page
  logic [OFF_W-1:0] dir_rd;

  sample_store #(.AW(DIR_AW), .DW(OFF_W)) u_dir (
    .core_clk (core_clk),
    .we       (ev_end),
    .waddr    ({bank_r, page_r}),
    .wdata    (wr_off_r),
    .re       (rd_take & rd_dir),
    .raddr    (rd_addr[DIR_AW-1:0]),
    .rdata    (dir_rd)
  );

  // ====================================================================
  // Readout path; one request in flight, buffer absorbs host stalls
  logic buf_in_ready;
  wire  [WORD_W-1:0] rd_word = dir_sel_r ? {7'h00, dir_rd} : grp_rd[grp_r];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pend_r     <= 1'b0;
      rd_ready_r <= 1'b0;
      grp_r      <= 2'h0;
      dir_sel_r  <= 1'b0;
    end
    else
    begin
      pend_r     <= rd_take;
      rd_ready_r <= !rd_take && !pend_r && buf_in_ready;
      if (rd_take)
      begin
        grp_r     <= rd_group;
        dir_sel_r <= rd_dir;
      end
    end
  end

  skid_buffer #(.DW(WORD_W)) u_buf (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (pend_r),
    .in_ready  (buf_in_ready),
    .in_data   (rd_word),
    .out_valid (rd_valid),
    .out_ready (rd_ack),
    .out_data  (rd_data)
  );

  // ====================================================================
  // Status outputs
  assign rd_ready    = rd_ready_r;
  assign trig_out    = trig_r;
  assign running     = state_r[1];
  assign armed_out   = !is_idle;
  assign bank_full   = full_r;
  assign active_bank = bank_r;
  assign page_num    = page_r;
  assign wr_ptr      = wr_off_r;

  // ====================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_run_at_end;
    state_r == ST_RUN && !single_shot && off_end && !stop_ev && !ev_end && arm;
  endsequence

  sequence s_page_done;
    ev_end && !last_pg && auto_start && arm;
  endsequence

  AST_TRIG_ARMED: assert property (
    trig_out && !trig_on_started |-> !$past(is_idle))
    else $error("trigger fired while not armed");
  AST_TRIG_STARTED: assert property (
    ($past(trig_on_started) && trig_out) |-> $past(started))
    else $error("trigger fired before acquisition started");
  AST_TRIG_CAUSE: assert property (
    trig_out |-> $past(any_hit))
    else $error("trigger without threshold hit");
  AST_WRAP: assert property (
    s_run_at_end |=> wr_off_r == OFF_RST && state_r == ST_RUN)
    else $error("circular write did not wrap");
  AST_AUTO_START: assert property (
    s_page_done |=> state_r == ST_RUN && page_r == $past(page_r) + 10'h001)
    else $error("auto start did not advance page");
  AST_GATE_START: assert property (
    state_r == ST_ARMED && gate_mode && gate_rise && bank_ok && arm
    |=> state_r == ST_RUN)
    else $error("gate leading edge did not start");
  AST_POST_END: assert property (
    post_done |=> state_r != ST_POST ##1 state_r != ST_POST || $past(arm))
    else $error("post trigger phase overran");
  AST_PAGE_LIMIT: assert property (
    !is_idle && $stable(multi_event) && $stable(size_shift) |-> page_r <= page_last)
    else $error("page number beyond configured count");
  AST_DEPTH: assert property (
    writing && $stable(size_shift) |-> wr_off_r <= mask)
    else $error("write offset beyond segment depth");
  AST_DIR_WRITE: assert property (
    ev_end |-> writing || $past(writing))
    else $error("directory written outside an event");

endmodule : acq_memory_trigger_ctrl

//--- verilog/acq_pkg.sv
// Shared constants, state type and address helpers for the acquisition block
package acq_pkg;

  // ====================================================================
  // Sizes
  localparam int SAMPLE_W  = 12;
  localparam int NUM_CH    = 8;
  localparam int NUM_GRP   = 4;
  localparam int GRP_CH    = 2;
  localparam int OFF_W     = 17;
  localparam int PAGE_W    = 10;
  localparam int MEM_AW    = OFF_W + 1;
  localparam int DIR_AW    = PAGE_W + 1;
  localparam int WORD_W    = GRP_CH * SAMPLE_W;
  localparam int BUF_DEPTH = 2;

  // ====================================================================
  // Limits and reset values
  localparam logic [OFF_W-1:0]  FULL_MASK = 17'h1ffff;
  localparam logic [3:0]        MAX_SHIFT = 4'ha;
  localparam logic [OFF_W-1:0]  OFF_RST   = 17'h00000;
  localparam logic [PAGE_W-1:0] PAGE_RST  = 10'h000;
  localparam logic [1:0]        FULL_RST  = 2'h0;

  // ====================================================================
  // States
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN   = 2'b10,
    ST_POST  = 2'b11
  } acq_state_t;

  // ====================================================================
  // Helpers
  function automatic logic [3:0] clip_shift(input logic [3:0] sh);
    return (sh > MAX_SHIFT) ? MAX_SHIFT : sh;
  endfunction : clip_shift

  // Last usable offset of one segment
  function automatic logic [OFF_W-1:0] seg_mask(input logic [3:0] sh);
    return FULL_MASK >> clip_shift(sh);
  endfunction : seg_mask

  // First location of a page
  function automatic logic [OFF_W-1:0] page_base(input logic [PAGE_W-1:0] pg,
                                                 input logic [3:0] sh);
    logic [OFF_W+PAGE_W-1:0] t;
    t = {pg, OFF_RST} >> clip_shift(sh);
    return t[OFF_W-1:0];
  endfunction : page_base

endpackage : acq_pkg

//--- verilog/sample_store.sv
// Simple dual-port memory with registered read data
`timescale 1ns/10ps
module sample_store #(
  parameter int AW = 18,
  parameter int DW = 24
) (
  // Clock
  input  wire logic          core_clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] ram [2**AW];

  always_ff @(posedge core_clk)
  begin
    if (we)
      ram[waddr] <= wdata;
    if (re)
      rdata <= ram[raddr];
  end

endmodule : sample_store

//--- verilog/skid_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module skid_buffer #(
  parameter int DW = 24
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset,
  // Filling side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [DW-1:0] in_data,
  // Draining side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic      [DW-1:0] out_data
);

  logic [DW-1:0] slot_r [2];
  logic [1:0]    count_r;
  logic          wp_r;
  logic          rp_r;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = slot_r[rp_r];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      count_r <= 2'h0;
      wp_r    <= 1'b0;
      rp_r    <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      slot_r[wp_r] <= in_data;
  end

endmodule : skid_buffer
